/* hw/ssp_top.sv */
// Start-up sequence selector, position error check and move distance sign handling
//
// Operation
// R1: After reset the block samples programmable input lines one to four to choose a start-up routine.
// R2: The selection index has input four as its top bit and input one as its bottom bit, values 0 to 15.
// R3: The index is looked up in the stored sequence directory, reserved entries 0 to 15 matching the 16 combinations.
// R4: When the looked-up entry is present, it is started at once on closure of the start input.
// R5: An empty automatic power-up sequence runs nothing and leaves start-up to the selected sequence.
// R6: Position error is feedback tally times motor steps per turn over encoder ticks per turn, less step position.
// R7: The error is given signed, but as its magnitude when requested for a conditional comparison.
// R8: Loading the move distance from a signed value sets direction from its sign; copying it out applies the sign.
// R9: Encoder ticks per turn is four times the encoder line count.
// R10: With no matching stored entry, closing the start input starts nothing.
`timescale 1ns/1ps

module ssp_top (
	// Clock and reset
	input  wire logic                                  clk_sys,
	input  wire logic                                  resetn,
	// Switch inputs
	input  wire logic [ssp_pkg::SEL_BITS-1:0]          prog_in,
	input  wire logic                                  start_in,
	// Sequence directory load
	input  wire logic                                  store_wr,
	input  wire logic [ssp_pkg::SEL_BITS-1:0]          store_wr_idx,
	input  wire ssp_pkg::ssp_entry_t                   store_wr_entry,
	// Automatic power-up sequence
	input  wire logic                                  config_present,
	input  wire logic                                  config_done,
	// Start-up outputs
	output logic                                       config_start,
	output logic                                       seq_start,
	output logic                                       start_refused,
	output logic [ssp_pkg::SEL_BITS-1:0]               sel_index,
	output logic [ssp_pkg::HANDLE_BITS-1:0]            seq_handle,
	output logic                                       armed,
	// Position check request
	input  wire logic                                  check_req,
	input  wire logic                                  check_cond,
	input  wire ssp_pkg::ssp_pos_in_t                  pos_in,
	// Position check result
	output logic signed [ssp_pkg::COUNT_BITS-1:0]      position_error_value,
	output logic                                       error_valid,
	output logic                                       error_fault,
	// Index move distance
	input  wire logic                                  load_from_var,
	input  wire logic signed [ssp_pkg::COUNT_BITS-1:0] var_value,
	input  wire logic                                  copy_req,
	output logic [ssp_pkg::DIST_BITS-1:0]              move_distance,
	output logic                                       move_dir,
	output logic signed [ssp_pkg::COUNT_BITS-1:0]      copy_value,
	output logic                                       copy_valid
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Magnitude of a signed count; the most negative value is clamped by callers
	function automatic logic [ssp_pkg::COUNT_BITS-1:0] mag(
		input logic signed [ssp_pkg::COUNT_BITS-1:0] v
	);
		mag = v[ssp_pkg::COUNT_BITS-1] ? ssp_pkg::COUNT_BITS'(-v) : ssp_pkg::COUNT_BITS'(v);
	endfunction : mag

	// ----------------------------------------------------------------
	// Start-up selection
	// ----------------------------------------------------------------

	ssp_pkg::ssp_state_t state;
	ssp_pkg::ssp_state_t next_state;
	ssp_pkg::ssp_entry_t rd_entry;
	ssp_pkg::ssp_entry_t sel_entry;
	logic                start_prev;
	logic                start_close;

	// Directory of stored sequences, read at the selection index
	ssp_seq_store #(
		.DEPTH (ssp_pkg::SEQ_COUNT),
		.WIDTH (ssp_pkg::ENTRY_BITS),
		.ABITS (ssp_pkg::SEL_BITS)
	) u_store (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.wr_en   (store_wr),
		.wr_addr (store_wr_idx),
		.wr_data (store_wr_entry),
		.rd_addr (sel_index),                               // see R3
		.rd_data (rd_entry)
	);

	// Closure of the start contact is taken as its rising edge
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			start_prev <= 1'b0;
		end else begin
			start_prev <= start_in;
		end
	end

	assign start_close = start_in && !start_prev;

	// State transitions
	always_comb begin
		next_state = state;
		case (state)
			ssp_pkg::ST_SAMPLE: begin
				next_state = ssp_pkg::ST_LOOKUP;
			end
			ssp_pkg::ST_LOOKUP: begin
				next_state = ssp_pkg::ST_CHECK;             // Wait for registered read data
			end
			ssp_pkg::ST_CHECK: begin
				// Empty power-up sequence is skipped outright
				next_state = config_present ? ssp_pkg::ST_CONFIG : ssp_pkg::ST_ARMED;  // see R5
			end
			ssp_pkg::ST_CONFIG: begin
				if (config_done) begin
					next_state = ssp_pkg::ST_ARMED;
				end
			end
			ssp_pkg::ST_ARMED: begin
				next_state = ssp_pkg::ST_ARMED;
			end
			default: begin
				next_state = ssp_pkg::ST_SAMPLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			state <= ssp_pkg::ST_SAMPLE;
		end else begin
			state <= next_state;
		end
	end

	// Selection index is caught once, in the first cycle after reset release
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			sel_index <= '0;
		end else if (state == ssp_pkg::ST_SAMPLE) begin
			sel_index <= {prog_in[3], prog_in[2], prog_in[1], prog_in[0]};  // see R1, R2
		end
	end

	// Directory entry for the selected sequence is held for the rest of the power-up
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			sel_entry <= '0;
		end else if (state == ssp_pkg::ST_CHECK) begin
			sel_entry <= rd_entry;                          // see R3
		end
	end

	// Power-up sequence launch, one pulse only when it holds something
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			config_start <= 1'b0;
		end else begin
			config_start <= (state == ssp_pkg::ST_CHECK) && config_present;  // see R5
		end
	end

	// Start closure launches the selected sequence or is refused.
	// Closures while the power-up sequence still runs are ignored, so the two never overlap.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			seq_start     <= 1'b0;
			start_refused <= 1'b0;
			seq_handle    <= '0;
		end else begin
			seq_start     <= 1'b0;
			start_refused <= 1'b0;
			if ((state == ssp_pkg::ST_ARMED) && start_close) begin
				if (sel_entry.present) begin
					seq_start  <= 1'b1;                     // see R4
					seq_handle <= sel_entry.handle;
				end else begin
					start_refused <= 1'b1;                  // see R10
				end
			end
		end
	end

	assign armed = (state == ssp_pkg::ST_ARMED);

	// ----------------------------------------------------------------
	// Position error check
	// ----------------------------------------------------------------

	localparam int PROD_BITS = ssp_pkg::COUNT_BITS + ssp_pkg::RES_BITS + 1;
	localparam int TICK_BITS = ssp_pkg::RES_BITS + ssp_pkg::QUAD_SHIFT;

	logic [TICK_BITS-1:0]        ticks;
	logic signed [PROD_BITS-1:0] prod;
	logic signed [PROD_BITS-1:0] quot;
	logic signed [PROD_BITS:0]   diff;
	logic signed [ssp_pkg::COUNT_BITS-1:0] err_sat;

	// Ticks per turn from the line count
	assign ticks = {pos_in.encoder_lines, {ssp_pkg::QUAD_SHIFT{1'b0}}};  // see R9

	// Scale the tally into motor steps; truncation is toward zero.
	// Done in one cycle at 25 MHz: wide but slow enough, and avoids a multi-cycle handshake.
	assign prod = PROD_BITS'(pos_in.feedback_tally) *
	              PROD_BITS'($signed({1'b0, pos_in.motor_steps_per_rev}));
	// Zero arm is a signed constant so the whole choice, and the division, stay signed
	assign quot = (ticks == '0) ? PROD_BITS'(0) : prod / PROD_BITS'($signed({1'b0, ticks}));  // see R6
	assign diff = (PROD_BITS+1)'(quot) - (PROD_BITS+1)'(pos_in.step_position_count);  // see R6

	// Clamp to the reportable range of plus or minus 9,999,999
	always_comb begin
		if (diff > (PROD_BITS+1)'(ssp_pkg::ERR_LIMIT)) begin
			err_sat = ssp_pkg::ERR_LIMIT;
		end else if (diff < -(PROD_BITS+1)'(ssp_pkg::ERR_LIMIT)) begin
			err_sat = -ssp_pkg::ERR_LIMIT;
		end else begin
			err_sat = ssp_pkg::COUNT_BITS'(diff);
		end
	end

	// Result register; a zero resolution takes the quotient as zero, leaving minus the step position, and raises the fault flag
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			position_error_value <= '0;
			error_valid          <= 1'b0;
			error_fault          <= 1'b0;
		end else begin
			error_valid <= check_req;
			if (check_req) begin
				error_fault <= (ticks == '0);
				if (check_cond) begin
					position_error_value <= $signed(mag(err_sat));  // see R7
				end else begin
					position_error_value <= err_sat;           // see R7
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Index move distance and direction
	// ----------------------------------------------------------------

	logic [ssp_pkg::COUNT_BITS-1:0] var_mag;

	assign var_mag = mag(var_value);

	// Load splits sign and magnitude; large magnitudes clamp to the distance limit
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			move_distance <= '0;
			move_dir      <= 1'b0;
		end else if (load_from_var) begin
			move_dir <= var_value[ssp_pkg::COUNT_BITS-1];  // see R8
			if (var_mag > ssp_pkg::COUNT_BITS'(ssp_pkg::DIST_LIMIT)) begin
				move_distance <= ssp_pkg::DIST_LIMIT;
			end else begin
				move_distance <= ssp_pkg::DIST_BITS'(var_mag);
			end
		end
	end

	// Copy out rebuilds the signed value from direction and magnitude
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			copy_value <= '0;
			copy_valid <= 1'b0;
		end else begin
			copy_valid <= copy_req;
			if (copy_req) begin
				copy_value <= move_dir ? -$signed(ssp_pkg::COUNT_BITS'(move_distance))
				                       : $signed(ssp_pkg::COUNT_BITS'(move_distance));  // see R8
			end
		end
	end

endmodule : ssp_top

/* pkg/ssp_pkg.sv */
// Shared constants and types for the start-up selector and position check block
package ssp_pkg;

	// ----------------------------------------------------------------
	// Start-up selection
	// ----------------------------------------------------------------
	localparam int SEL_BITS    = 4;                 // Programmable input lines used for selection
	localparam int SEQ_COUNT   = 16;                // Reserved sequences 0..15
	localparam int HANDLE_BITS = 16;                // Width of a stored sequence entry handle

	// Stored sequence directory entry
	typedef struct packed {
		logic                   present;
		logic [HANDLE_BITS-1:0] handle;
	} ssp_entry_t;

	localparam int ENTRY_BITS = $bits(ssp_entry_t);

	// Start-up state machine, one-hot
	typedef enum logic [4:0] {
		ST_SAMPLE = 5'h01,
		ST_LOOKUP = 5'h02,
		ST_CHECK  = 5'h04,
		ST_CONFIG = 5'h08,
		ST_ARMED  = 5'h10
	} ssp_state_t;

	// ----------------------------------------------------------------
	// Position check
	// ----------------------------------------------------------------
	localparam int COUNT_BITS  = 32;                // Encoder and position counters
	localparam int RES_BITS    = 16;                // Motor steps and encoder lines per turn
	localparam int QUAD_SHIFT  = 2;                 // Quadrature gives four ticks per line
	localparam int DIST_BITS   = 24;                // Move distance magnitude
	localparam logic signed [COUNT_BITS-1:0] ERR_LIMIT  = 32'sh0098_967f;  // 9,999,999
	localparam logic [DIST_BITS-1:0]         DIST_LIMIT = 24'h98_967f;     // 9,999,999

	// Inputs to the position error computation
	typedef struct packed {
		logic signed [COUNT_BITS-1:0] feedback_tally;
		logic signed [COUNT_BITS-1:0] step_position_count;
		logic [RES_BITS-1:0]          motor_steps_per_rev;
		logic [RES_BITS-1:0]          encoder_lines;
	} ssp_pos_in_t;

endpackage : ssp_pkg

/* hw/ssp_seq_store.sv */
// Small directory memory of stored sequences with registered read data
`timescale 1ns/1ps

module ssp_seq_store #(
	parameter int DEPTH = 16,
	parameter int WIDTH = 17,
	parameter int ABITS = 4
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             resetn,
	// Write port
	input  wire logic             wr_en,
	input  wire logic [ABITS-1:0] wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	// Read port
	input  wire logic [ABITS-1:0] rd_addr,
	output logic      [WIDTH-1:0] rd_data
);

	logic [WIDTH-1:0] mem [DEPTH];

	// Storage array; contents stand for the nonvolatile store, so reset leaves them alone
	always_ff @(posedge clk_sys) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// Registered read, cleared by reset so nothing reads as present while reset is held
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			rd_data <= '0;
		end else begin
			rd_data <= mem[rd_addr];
		end
	end

endmodule : ssp_seq_store

/* tb/ssp_top_asserts.sv */
// Port-level checks for the start-up selector and position check block
`timescale 1ns/1ps

module ssp_chk (
	// Clock and reset
	input wire logic                                  clk_sys,
	input wire logic                                  resetn,
	// Start-up side
	input wire logic                                  start_in,
	input wire logic                                  config_present,
	input wire logic                                  config_start,
	input wire logic                                  seq_start,
	input wire logic                                  start_refused,
	input wire logic [ssp_pkg::SEL_BITS-1:0]          sel_index,
	input wire logic                                  armed,
	// Position check and distance
	input wire logic                                  check_req,
	input wire logic                                  check_cond,
	input wire logic signed [ssp_pkg::COUNT_BITS-1:0] position_error_value,
	input wire logic                                  error_valid,
	input wire logic                                  load_from_var,
	input wire logic signed [ssp_pkg::COUNT_BITS-1:0] var_value,
	input wire logic                                  copy_req,
	input wire logic [ssp_pkg::DIST_BITS-1:0]         move_distance,
	input wire logic                                  move_dir,
	input wire logic signed [ssp_pkg::COUNT_BITS-1:0] copy_value,
	input wire logic                                  copy_valid
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	// ------------------------------------------------------------
	// Start-up
	// ------------------------------------------------------------
	a_close_answer: assert property (armed && $rose(start_in) |=> seq_start || start_refused)
		else $error("closure while armed got no answer");
	a_close_unarmed: assert property (!armed |=> !seq_start && !start_refused)
		else $error("start answer without an armed closure");
	a_pulse_excl: assert property (!(seq_start && start_refused))
		else $error("launch and refusal together");
	a_cfg_gate: assert property (config_start |-> $past(config_present))
		else $error("empty power-up sequence was launched");
	a_sel_hold: assert property (armed |-> $stable(sel_index))
		else $error("selection index moved after sampling");

	// ------------------------------------------------------------
	// Position check and distance
	// ------------------------------------------------------------
	a_err_valid: assert property (check_req |=> error_valid)
		else $error("check request got no result");
	a_err_hold: assert property (!check_req |=> $stable(position_error_value))
		else $error("error value changed without request");
	a_cond_abs: assert property (check_req && check_cond |=> !position_error_value[31])
		else $error("conditional result is negative");
	a_dir_load: assert property (load_from_var |=> move_dir == ($past(var_value) < 0))
		else $error("direction not taken from sign");
	a_copy_sign: assert property (copy_req |=> copy_valid && copy_value == ($past(move_dir) ?
		-$signed({8'h00, $past(move_distance)}) : $signed({8'h00, $past(move_distance)})))
		else $error("copied distance has wrong value");
endmodule : ssp_chk

bind ssp_top ssp_chk chk_u (.clk_sys, .resetn, .start_in, .config_present, .config_start, .seq_start,
	.start_refused, .sel_index, .armed, .check_req, .check_cond, .position_error_value, .error_valid,
	.load_from_var, .var_value, .copy_req, .move_distance, .move_dir, .copy_value, .copy_valid);

/* tb/ssp_far_model.sv */
// Model of the power-up sequence runner on the far side of the block
`timescale 1ns/1ps

module ssp_far_model #(
	parameter int DLY = 8
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// Power-up sequence handshake
	input wire logic config_start,
	output logic     config_done
);
	int cnt;

	// Runs only once launched, so an empty sequence never reports done
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			cnt         <= 0;
			config_done <= 1'b0;
		end else begin
			config_done <= (cnt == 1);
			if (config_start) begin
				cnt <= DLY;
			end else if (cnt != 0) begin
				cnt <= cnt - 1;
			end
		end
	end
endmodule : ssp_far_model

/* tb/test_startup_select_position_check.sv */
// Self-checking bench for the start-up selector and position check block
`timescale 1ns/1ps

module test_startup_select_position_check;
	logic                 clk_sys = 1'b0;
	logic                 resetn = 1'b0;
	logic [3:0]           prog_in = 4'h0;
	logic                 start_in = 1'b0;
	logic                 store_wr = 1'b0;
	logic [3:0]           store_wr_idx = 4'h0;
	ssp_pkg::ssp_entry_t  store_wr_entry = '0;
	logic                 config_present = 1'b0;
	logic                 check_req = 1'b0;
	logic                 check_cond = 1'b0;
	ssp_pkg::ssp_pos_in_t pos_in = '0;
	logic                 load_from_var = 1'b0;
	logic signed [31:0]   var_value = 32'sh0;
	logic                 copy_req = 1'b0;
	logic                 config_done, config_start, seq_start, start_refused, armed;
	logic                 error_valid, error_fault, move_dir, copy_valid;
	logic [3:0]           sel_index;
	logic [15:0]          seq_handle;
	logic signed [31:0]   position_error_value, copy_value;
	logic [23:0]          move_distance;
	int                   miscompares = 0;
	int                   tests_run = 0;
	int                   cycles = 0;
	int                   cfg_runs = 0;

	always #20 clk_sys = ~clk_sys;

	ssp_top dut_u (.clk_sys, .resetn, .prog_in, .start_in, .store_wr, .store_wr_idx, .store_wr_entry,
		.config_present, .config_done, .config_start, .seq_start, .start_refused, .sel_index, .seq_handle,
		.armed, .check_req, .check_cond, .pos_in, .position_error_value, .error_valid, .error_fault,
		.load_from_var, .var_value, .copy_req, .move_distance, .move_dir, .copy_value, .copy_valid);
	ssp_far_model #(.DLY(8)) far_u (.clk_sys, .resetn, .config_start, .config_done);

	task tick;
		@(posedge clk_sys);
		#1;
	endtask : tick

	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task test_done;
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : test_done

	// Switches are set while reset holds, as at power-up
	task boot(input logic [3:0] sel, input logic cfg);
		resetn = 1'b0;
		prog_in = sel;
		config_present = cfg;
		repeat (5) tick;
		cfg_runs = 0;
		resetn = 1'b1;
		tick;
		chk("sel_index", sel_index, sel);
		prog_in = ~sel;
		for (int i = 0; i < 40 && armed !== 1'b1; i++) begin
			tick;
		end
		chk("armed", armed, 1'b1);
		chk("config_runs", cfg_runs, cfg);
	endtask : boot

	task close(input logic go, input logic [15:0] h);
		start_in = 1'b1;
		tick;
		start_in = 1'b0;
		chk("seq_start", seq_start, go);
		chk("start_refused", start_refused, !go);
		chk("seq_handle", seq_handle, go ? h : 16'h0000);
		tick;
		chk("seq_start_end", seq_start, 1'b0);
	endtask : close

	// Every switch code, even entries stored, odd ones missing; back-to-back closures
	task t_select;
		for (int i = 0; i < 16; i++) begin
			boot(i[3:0], 1'b0);
			close(!i[0], 16'ha500 + 16'(i));
			close(!i[0], 16'ha500 + 16'(i));
		end
	endtask : t_select

	// A closure while the power-up sequence runs is ignored
	task t_config;
		resetn = 1'b0;
		prog_in = 4'h2;
		config_present = 1'b1;
		repeat (5) tick;
		cfg_runs = 0;
		resetn = 1'b1;
		repeat (4) tick;
		start_in = 1'b1;
		tick;
		start_in = 1'b0;
		chk("busy_start", seq_start | start_refused, 1'b0);
		chk("busy_armed", armed, 1'b0);
		repeat (12) tick;
		chk("armed_after", armed, 1'b1);
		chk("config_runs_busy", cfg_runs, 32'h0000_0001);
		close(1'b1, 16'ha502);
	endtask : t_config

	task pchk(input int t, input int p, input int ms, input int ln, input logic c);
		longint e;
		tick;
		e = ((ln == 0) ? 0 : (longint'(t) * ms) / (4 * ln)) - p;
		e = (e > 9999999) ? 9999999 : ((e < -9999999) ? -9999999 : e);
		e = (c && e < 0) ? -e : e;
		pos_in = '{t, p, 16'(ms), 16'(ln)};
		check_req = 1'b1;
		check_cond = c;
		tick;
		check_req = 1'b0;
		chk("error_valid", error_valid, 1'b1);
		chk("position_error_value", position_error_value, e[31:0]);
		chk("error_fault", error_fault, ln == 0);
	endtask : pchk

	task t_check;
		pchk(7996, 2000, 500, 500, 1'b0);
		pchk(7996, 2000, 500, 500, 1'b1);
		pchk(-7, 0, 1, 1, 1'b0);
		pchk(2000000000, 0, 100, 1, 1'b0);
		pchk(0, 20000000, 1, 1, 1'b1);
		pchk(5, 3, 1, 0, 1'b0);
		pchk(-7996, -2000, 500, 500, 1'b0);
		tick;
		chk("valid_end", error_valid, 1'b0);
		chk("value_held", position_error_value, 32'h0000_0001);
	endtask : t_check

	task ld(input int v, input int mag);
		tick;
		load_from_var = 1'b1;
		var_value = v;
		tick;
		load_from_var = 1'b0;
		chk("move_distance", move_distance, mag);
		chk("move_dir", move_dir, v < 0);
		copy_req = 1'b1;
		tick;
		copy_req = 1'b0;
		chk("copy_valid", copy_valid, 1'b1);
		chk("copy_value", copy_value, (v < 0) ? -mag : mag);
	endtask : ld

	// A copy on the same edge as a load sees the old distance
	task t_dist;
		ld(-8000, 8000);
		tick;
		load_from_var = 1'b1;
		var_value = 2000;
		copy_req = 1'b1;
		tick;
		load_from_var = 1'b0;
		copy_req = 1'b0;
		chk("copy_old", copy_value, -32'sd8000);
		ld(20000000, 9999999);
	endtask : t_dist

	initial begin
		for (int i = 0; i < 16; i++) begin
			store_wr = 1'b1;
			store_wr_idx = i[3:0];
			store_wr_entry = '{!i[0], 16'ha500 + 16'(i)};
			tick;
		end
		store_wr = 1'b0;
		t_select;
		t_config;
		t_check;
		t_dist;
		test_done;
	end

	// Cycle ceiling and power-up launch tally
	always @(posedge clk_sys) begin
		cycles++;
		if (config_start === 1'b1) begin
			cfg_runs++;
		end
		if (cycles == 20000) begin
			miscompares++;
			test_done;
		end
	end
endmodule : test_startup_select_position_check
